// ---- inc/adcsb_pkg.sv ----
`default_nettype none
package adcsb_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0]  ADDR_CONTROL_TWO   = 4'h0;
    localparam logic [3:0]  ADDR_IRQ_STATUS    = 4'h1;
    localparam logic [3:0]  ADDR_IRQ_MASK      = 4'h2;
    localparam logic [3:0]  ADDR_SAMPLE_CTRL   = 4'h3;
    localparam logic [3:0]  ADDR_MUX_SETTINGS  = 4'h4;
    localparam logic [3:0]  ADDR_SCAN_SELECT   = 4'h5;
    localparam logic [3:0]  ADDR_STATE         = 4'h6;

    // ************************************************************
    // Control register two fields
    // ************************************************************
    localparam int          VCFG_LSB           = 13;
    localparam int          RSVD_BIT           = 12;
    localparam int          SCAN_SELECT_BIT    = 10;
    localparam int          FILL_HALF_BIT      = 7;
    localparam int          SEQ_IRQ_LSB        = 2;
    localparam int          SPLIT_MODE_BIT     = 1;
    localparam int          ALT_MUX_BIT        = 0;
    // Writable bits: 15-13, 12, 10, 6-0 (11, 9-8, 7 not writable)
    localparam logic [15:0] CTRL2_WR_MASK      = 16'hF47F;
    localparam logic [15:0] CTRL2_RESET        = 16'h0000;

    // Sample control register fields
    localparam int          SAMPLE_REQUEST_REQ_BIT       = 0;
    localparam int          AUTO_CONV_BIT      = 1;

    // Interrupt status bits
    localparam int          IRQ_SEQ_BIT        = 0;
    localparam int          IRQ_DONE_BIT       = 1;
    localparam int          IRQ_BITS           = 2;

    // ************************************************************
    // Timing, in converter clock periods
    // ************************************************************
    localparam int          CONV_PERIODS       = 12;
    localparam int          SAMPLE_PERIODS     = 1;
    localparam int          START_DELAY_MIN    = 2;
    localparam int          START_DELAY_MAX    = 3;
    localparam logic [3:0]  CONV_CNT_LAST      = 4'(CONV_PERIODS - 1);
    localparam logic [1:0]  START_CNT_LAST     = 2'(START_DELAY_MIN - 1);
    localparam logic [3:0]  SAMPLE_CNT_LAST    = 4'(SAMPLE_PERIODS - 1);

    // Buffer geometry
    localparam int          BUF_WORDS          = 32;
    localparam int          HALF_WORDS         = 16;

    typedef enum logic [2:0] {
        ADCSB_IDLE,
        ADCSB_DELAY,
        ADCSB_SAMPLE,
        ADCSB_CONVERT
    } adcsb_state_t;
endpackage
`default_nettype wire

// ---- rtl/adcsb_control.sv ----
// The register offsets and the plain strobed port were left to the implementer.
`default_nettype none
module adcsb_control (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    // Register port
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [15:0] reg_rdata_o,
    // Converter front end
    input  wire logic [9:0]  conv_result_i,
    output logic             sampling_o,
    output logic             converting_o,
    output logic             mux_b_sel_o,
    output logic      [4:0]  chan_zero_positive_input_o,
    output logic             result_write_o,
    output logic      [4:0]  result_addr_o,
    output logic      [9:0]  result_buffer_word_o,
    // Interrupt
    output logic             irq_o
);
    import adcsb_pkg::*;

    // ************************************************************
    // Registers
    // ************************************************************
    logic [15:0]  ctrl2_ff;
    logic [1:0]   sample_request_ctrl_ff;
    logic [15:0]  mux_set_ff;
    logic [15:0]  scan_mask_ff;
    logic [IRQ_BITS-1:0] irq_stat_ff;
    logic [IRQ_BITS-1:0] irq_mask_ff;
    adcsb_state_t state_ff;
    logic [3:0]   cnt_ff;
    logic         alt_b_ff;
    logic [3:0]   scan_idx_ff;
    logic [3:0]   scan_chan;
    logic [4:0]   seq_cnt_ff;
    logic [4:0]   wr_ptr_ff;
    logic         fill_half_ff;
    logic [15:0]  rdata_ff;
    logic         seq_done;
    logic         wr_ctrl2;
    logic         sample_request_set_wr;

    // Index of next scan input at or after start, wrapping
    function automatic logic [3:0] next_scan(input logic [15:0] mask,
                                             input logic [3:0]  start);
        logic [3:0] idx;
        logic       found;
        idx   = 4'h0;
        found = 1'b0;
        for (int k = 0; k < 16; k++) begin
            if (!found && mask[4'(start + 4'(k))]) begin
                idx   = 4'(start + 4'(k));
                found = 1'b1;
            end
        end
        return idx;
    endfunction

    assign wr_ctrl2    = reg_wr_i && (reg_addr_i == ADDR_CONTROL_TWO);
    assign sample_request_set_wr = reg_wr_i && (reg_addr_i == ADDR_SAMPLE_CTRL)
                         && reg_wdata_i[SAMPLE_REQUEST_REQ_BIT];

    // ************************************************************
    // Software registers
    // ************************************************************
    // Control register two; unimplemented bits never stored
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ctrl2_ff <= CTRL2_RESET;
        end else if (wr_ctrl2) begin
            ctrl2_ff <= reg_wdata_i & CTRL2_WR_MASK;
        end
    end

    // Sample request, cleared by hardware once sampling ends
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sample_request_ctrl_ff <= 2'b00;
        end else if (reg_wr_i && (reg_addr_i == ADDR_SAMPLE_CTRL)) begin
            sample_request_ctrl_ff <= reg_wdata_i[1:0];
        end else if (state_ff == ADCSB_SAMPLE && cnt_ff == SAMPLE_CNT_LAST) begin
            sample_request_ctrl_ff[SAMPLE_REQUEST_REQ_BIT] <= 1'b0;
        end
    end

    // Mux settings (A in low byte, B in high byte) and scan mask
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            mux_set_ff   <= 16'h0000;
            scan_mask_ff <= 16'h0000;
        end else if (reg_wr_i) begin
            if (reg_addr_i == ADDR_MUX_SETTINGS) begin
                mux_set_ff <= reg_wdata_i;
            end
            if (reg_addr_i == ADDR_SCAN_SELECT) begin
                scan_mask_ff <= reg_wdata_i;
            end
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Start delay fixed at 2 periods: inside the allowed 2 to 3 window
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_ff <= ADCSB_IDLE;
            cnt_ff   <= 4'h0;
        end else begin
            case (state_ff)
                ADCSB_IDLE: begin
                    if (sample_request_set_wr) begin
                        state_ff <= ADCSB_DELAY;
                        cnt_ff   <= 4'h0;
                    end
                end
                ADCSB_DELAY: begin
                    if (cnt_ff[1:0] == START_CNT_LAST) begin
                        state_ff <= ADCSB_SAMPLE;
                        cnt_ff   <= 4'h0;
                    end else begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                end
                ADCSB_SAMPLE: begin
                    if (cnt_ff == SAMPLE_CNT_LAST) begin
                        state_ff <= ADCSB_CONVERT;
                        cnt_ff   <= 4'h0;
                    end else begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                end
                ADCSB_CONVERT: begin
                    if (cnt_ff == CONV_CNT_LAST) begin
                        cnt_ff <= 4'h0;
                        // Auto mode loops straight back into sampling
                        state_ff <= sample_request_ctrl_ff[AUTO_CONV_BIT] ? ADCSB_SAMPLE
                                                                : ADCSB_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                end
                default: begin
                    state_ff <= ADCSB_IDLE;
                    cnt_ff   <= 4'h0;
                end
            endcase
        end
    end

    assign seq_done     = (state_ff == ADCSB_CONVERT) && (cnt_ff == CONV_CNT_LAST);
    assign sampling_o   = (state_ff == ADCSB_SAMPLE);
    assign converting_o = (state_ff == ADCSB_CONVERT);

    // ************************************************************
    // Input selection
    // ************************************************************
    // Alternation restarts on mux A whenever the mode is written
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || wr_ctrl2) begin
            alt_b_ff <= 1'b0;
        end else if (seq_done) begin
            alt_b_ff <= ctrl2_ff[ALT_MUX_BIT] && !alt_b_ff;
        end
    end

    // Scan pointer steps only on mux A samples; resumes past the channel just used
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || wr_ctrl2) begin
            scan_idx_ff <= 4'h0;
        end else if (seq_done && !alt_b_ff && ctrl2_ff[SCAN_SELECT_BIT]) begin
            scan_idx_ff <= 4'(scan_chan + 4'h1);
        end
    end

    assign scan_chan   = next_scan(scan_mask_ff, scan_idx_ff);
    assign mux_b_sel_o = alt_b_ff;
    // Scan overrides the fixed mux A channel; B always uses its own
    assign chan_zero_positive_input_o =
        alt_b_ff ? mux_set_ff[12:8]
                 : (ctrl2_ff[SCAN_SELECT_BIT]
                    ? {1'b0, scan_chan}
                    : mux_set_ff[4:0]);

    // ************************************************************
    // Result buffer and interrupt count
    // ************************************************************
    // Pointer and half flip restart when an interrupt point is reached
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || wr_ctrl2) begin
            seq_cnt_ff   <= 5'h00;
            wr_ptr_ff    <= 5'h00;
            fill_half_ff <= 1'b0;
        end else if (seq_done) begin
            if (seq_cnt_ff == ctrl2_ff[SEQ_IRQ_LSB +: 5]) begin
                seq_cnt_ff <= 5'h00;
                if (ctrl2_ff[SPLIT_MODE_BIT]) begin
                    fill_half_ff <= !fill_half_ff;
                end
                wr_ptr_ff <= 5'h00;
            end else begin
                seq_cnt_ff <= seq_cnt_ff + 5'h01;
                wr_ptr_ff  <= wr_ptr_ff + 5'h01;
            end
        end
    end

    // Capture the result on the last conversion period; the write strobe and address register on the same edge as the word
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            result_write_o       <= 1'b0;
            result_addr_o        <= 5'h00;
            result_buffer_word_o <= 10'h000;
        end else begin
            result_write_o       <= seq_done;
            result_buffer_word_o <= seq_done ? conv_result_i : result_buffer_word_o;
            if (seq_done) begin
                result_addr_o <= ctrl2_ff[SPLIT_MODE_BIT]
                    ? {fill_half_ff, wr_ptr_ff[3:0]}
                    : wr_ptr_ff;
            end
        end
    end

    // Sticky events: set wins over write-one-to-clear
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            irq_stat_ff <= '0;
            irq_mask_ff <= '0;
        end else begin
            if (reg_wr_i && reg_addr_i == ADDR_IRQ_MASK) begin
                irq_mask_ff <= reg_wdata_i[IRQ_BITS-1:0];
            end
            irq_stat_ff <= (irq_stat_ff
                            & ~((reg_wr_i && reg_addr_i == ADDR_IRQ_STATUS)
                                ? reg_wdata_i[IRQ_BITS-1:0] : 2'b00))
                         | {seq_done,
                            seq_done && seq_cnt_ff == ctrl2_ff[SEQ_IRQ_LSB +: 5]};
        end
    end

    assign irq_o = |(irq_stat_ff & irq_mask_ff);

    // ************************************************************
    // Read port
    // ************************************************************
    // Unmapped offsets read zero
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_ff <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_CONTROL_TWO: begin
                    rdata_ff <= (ctrl2_ff & CTRL2_WR_MASK)
                              | (16'(fill_half_ff && ctrl2_ff[SPLIT_MODE_BIT])
                                 << FILL_HALF_BIT);
                end
                ADDR_IRQ_STATUS:   rdata_ff <= {14'h0000, irq_stat_ff};
                ADDR_IRQ_MASK:     rdata_ff <= {14'h0000, irq_mask_ff};
                ADDR_SAMPLE_CTRL:  rdata_ff <= {14'h0000, sample_request_ctrl_ff};
                ADDR_MUX_SETTINGS: rdata_ff <= mux_set_ff;
                ADDR_SCAN_SELECT:  rdata_ff <= scan_mask_ff;
                ADDR_STATE:        rdata_ff <= {8'h00, 3'(state_ff), wr_ptr_ff};
                default:           rdata_ff <= 16'h0000;
            endcase
        end else begin
            rdata_ff <= 16'h0000;
        end
    end

    assign reg_rdata_o = rdata_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_req;
        state_ff == ADCSB_IDLE && sample_request_set_wr;
    endsequence

    sequence s_start;
        ##[2:3] state_ff == ADCSB_SAMPLE;
    endsequence

    AST_START_DELAY: assert property (
        @(posedge ref_clk_i) disable iff (reset_i) s_req |-> s_start)
        else $error("Sampling did not start 2 to 3 clocks after request");

    AST_CONV_LEN: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        (state_ff == ADCSB_SAMPLE && $past(state_ff) != ADCSB_SAMPLE)
        |=> converting_o [*8] ##1 converting_o [*4] ##1 !converting_o)
        else $error("Conversion not 12 clocks long");

    AST_SAMPLE_LEN: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        $rose(sampling_o) |=> !sampling_o && converting_o)
        else $error("Sampling not 1 clock long");

    AST_UNIMPL_ZERO: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        $past(reg_rd_i) && $past(reg_addr_i) == ADDR_CONTROL_TWO
        |-> reg_rdata_o[11] == 1'b0 && reg_rdata_o[9:8] == 2'b00)
        else $error("Unimplemented control bits read nonzero");

    AST_ALT_OFF: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        !ctrl2_ff[ALT_MUX_BIT] && !$past(wr_ctrl2) |-> !mux_b_sel_o)
        else $error("Mux B used without alternate sampling");

    AST_ALT_TOGGLE: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        seq_done && ctrl2_ff[ALT_MUX_BIT] && !wr_ctrl2
        |=> mux_b_sel_o != $past(mux_b_sel_o))
        else $error("Alternate sampling did not swap mux");

    AST_IRQ_COUNT: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        seq_done && !wr_ctrl2 |=> irq_stat_ff[IRQ_SEQ_BIT]
            == ($past(seq_cnt_ff) == ctrl2_ff[SEQ_IRQ_LSB +: 5]
                || $past(irq_stat_ff[IRQ_SEQ_BIT])
                   && !($past(reg_wr_i) && $past(reg_addr_i) == ADDR_IRQ_STATUS
                        && $past(reg_wdata_i[IRQ_SEQ_BIT]))))
        else $error("Sequence interrupt at wrong count");

    AST_HALF_ADDR: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        result_write_o && ctrl2_ff[SPLIT_MODE_BIT] && !$past(wr_ctrl2)
        |-> result_addr_o[4] == $past(fill_half_ff))
        else $error("Split buffer write in wrong half");

    AST_SCAN_OFF: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        !ctrl2_ff[SCAN_SELECT_BIT] && !mux_b_sel_o
        |-> chan_zero_positive_input_o == mux_set_ff[4:0])
        else $error("Scanning while scan select clear");
endmodule // adcsb_control
`default_nettype wire

// ---- verif/adcsb_frontend_model.sv ----
`default_nettype none
// ************************************************************
// Converter front end model
// ************************************************************
module adcsb_frontend_model (
    // Clock
    input  wire logic       ref_clk_i,
    // Control from the sequencer
    input  wire logic       sampling_i,
    input  wire logic       converting_i,
    input  wire logic       mux_b_sel_i,
    input  wire logic [4:0] chan_i,
    // Result back to the sequencer
    output logic      [9:0] conv_result_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] sample_cnt_ff = 4'h0;
    logic [9:0] held_ff       = 10'h000;

    // Capture the selection while the hold cap charges; count tags each result
    always_ff @(posedge ref_clk_i) begin
        if (sampling_i) begin
            held_ff       <= {sample_cnt_ff, mux_b_sel_i, chan_i};
            sample_cnt_ff <= sample_cnt_ff + 4'h1;
        end
    end

    // Outside conversion show the inverse, so a late or early capture is caught
    assign conv_result_o = converting_i ? held_ff : ~held_ff;
endmodule // adcsb_frontend_model
`default_nettype wire

// ---- verif/testbench.sv ----
`default_nettype none
`define TB_CHK(what, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("unexpected %s: expected %h seen %h", what, exp, got); \
        end \
    end
// ************************************************************
// Self-checking bench
// ************************************************************
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import adcsb_pkg::*;

    logic        clk         = 1'b0;
    logic        rst         = 1'b1;
    logic [3:0]  reg_addr    = 4'h0;
    logic [15:0] reg_wdata   = 16'h0000;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic [15:0] reg_rdata;
    logic [9:0]  conv_result;
    logic        sampling;
    logic        converting;
    logic        mux_b_sel;
    logic [4:0]  chan;
    logic        result_write;
    logic [4:0]  result_addr;
    logic [9:0]  result_word;
    logic        irq;
    int          fail_count  = 0;
    int          checked     = 0;
    logic [3:0]  sample_no   = 4'h0;
    logic        rd_wait     = 1'b0;
    logic [4:0]  ca;
    logic [4:0]  cb;
    logic [15:0] rd_q[$];
    logic [14:0] res_q[$];

    // Clock at 50 MHz; stands in for the converter clock, so a real 75 ns
    // or longer converter clock only stretches each phase in time
    always #10 clk = ~clk;

    adcsb_control dut (
        .ref_clk_i                  (clk),
        .reset_i                    (rst),
        .reg_addr_i                 (reg_addr),
        .reg_wdata_i                (reg_wdata),
        .reg_wr_i                   (reg_wr),
        .reg_rd_i                   (reg_rd),
        .reg_rdata_o                (reg_rdata),
        .conv_result_i              (conv_result),
        .sampling_o                 (sampling),
        .converting_o               (converting),
        .mux_b_sel_o                (mux_b_sel),
        .chan_zero_positive_input_o (chan),
        .result_write_o             (result_write),
        .result_addr_o              (result_addr),
        .result_buffer_word_o       (result_word),
        .irq_o                      (irq)
    );

    adcsb_frontend_model front (
        .ref_clk_i     (clk),
        .sampling_i    (sampling),
        .converting_i  (converting),
        .mux_b_sel_i   (mux_b_sel),
        .chan_i        (chan),
        .conv_result_o (conv_result)
    );

    // Verdict and end of run, shared by the main sequence and the watchdog
    task automatic complete_run();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Single-cycle write strobe
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // Single-cycle read strobe; the monitor checks the data one cycle later
    task automatic reg_read(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        rd_q.push_back(exp);
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask

    // Count settled cycles a signal holds a level, bounded against hangs
    task automatic count_while(ref logic sig, input logic lvl, output int n);
        n = 0;
        while (sig === lvl && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    // Level checked once the previous edge's updates have landed
    task automatic check_irq(input logic exp);
        @(posedge clk);
        #1;
        `TB_CHK("interrupt level", exp, irq)
    endtask

    // One software-started sample and conversion with its expected result
    task automatic run_sample(input logic mb, input logic [4:0] ch, input logic [4:0] ad);
        int n;
        res_q.push_back({ad, sample_no, mb, ch});
        sample_no = sample_no + 4'h1;
        reg_write(ADDR_SAMPLE_CTRL, 16'h0001);
        count_while(sampling, 1'b0, n);
        `TB_CHK("start delay", 1'b1, (n >= START_DELAY_MIN && n <= START_DELAY_MAX))
        count_while(sampling, 1'b1, n);
        `TB_CHK("sample periods", SAMPLE_PERIODS, n)
        count_while(converting, 1'b1, n);
        `TB_CHK("conversion periods", CONV_PERIODS, n)
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Result and read-data monitor; samples midway between edges
    always @(negedge clk) begin
        logic [14:0] r;
        logic [15:0] e;
        if (rd_wait) begin
            e = rd_q.pop_front();
            `TB_CHK("read data", e, reg_rdata)
        end
        rd_wait = reg_rd;
        if (result_write === 1'b1) begin
            r = res_q.pop_front();
            `TB_CHK("result address", r[14:10], result_addr)
            `TB_CHK("result word", r[9:0], result_word)
        end
    end

    // Watchdog: all tests together take about a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        complete_run();
    end

    // Main sequence
    initial begin
        void'($urandom(55));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        reg_read(ADDR_CONTROL_TWO, CTRL2_RESET);
        reg_read(ADDR_IRQ_STATUS, 16'h0000);
        reg_write(ADDR_CONTROL_TWO, 16'hEFFF);
        reg_read(ADDR_CONTROL_TWO, 16'hEFFF & CTRL2_WR_MASK);
        reg_read(4'hF, 16'h0000);
        // Alternating mux, interrupt every sequence
        ca = 5'($urandom_range(0, 31));
        cb = ca ^ 5'($urandom_range(1, 31));
        reg_write(ADDR_MUX_SETTINGS, {3'h0, cb, 3'h0, ca});
        reg_write(ADDR_IRQ_MASK, 16'h0001);
        reg_write(ADDR_CONTROL_TWO, 16'h0001);
        reg_write(ADDR_IRQ_STATUS, 16'h0003);
        for (int k = 0; k < 4; k++) begin
            run_sample(k[0], k[0] ? cb : ca, 5'h00);
            check_irq(1'b1);
        end
        reg_write(ADDR_IRQ_MASK, 16'h0000);
        check_irq(1'b0);
        reg_write(ADDR_IRQ_MASK, 16'h0001);
        check_irq(1'b1);
        reg_write(ADDR_IRQ_STATUS, 16'h0001);
        check_irq(1'b0);
        // Scanning into split halves, four sequences per interrupt
        reg_write(ADDR_SCAN_SELECT, 16'h0024);
        reg_write(ADDR_CONTROL_TWO, 16'h040E);
        reg_write(ADDR_IRQ_STATUS, 16'h0003);
        for (int k = 0; k < 8; k++) begin
            run_sample(1'b0, k[0] ? 5'd5 : 5'd2, {k[2], 2'b00, k[1:0]});
            if (k == 2) begin
                reg_read(ADDR_IRQ_STATUS, 16'h0002);
                check_irq(1'b0);
            end
            if (k == 3) begin
                check_irq(1'b1);
                reg_read(ADDR_CONTROL_TWO, 16'h048E);
                reg_write(ADDR_IRQ_STATUS, 16'h0003);
            end
        end
        reg_read(ADDR_CONTROL_TWO, 16'h040E);
        // Single buffer, mux A only, interrupt every 32nd sequence
        ca = 5'($urandom_range(0, 31));
        cb = ca ^ 5'($urandom_range(1, 31));
        reg_write(ADDR_MUX_SETTINGS, {3'h0, cb, 3'h0, ca});
        reg_write(ADDR_CONTROL_TWO, 16'h007C);
        reg_write(ADDR_IRQ_STATUS, 16'h0003);
        for (int k = 0; k < 32; k++) begin
            run_sample(1'b0, ca, 5'(k));
            if (k == 30) begin
                check_irq(1'b0);
            end
        end
        check_irq(1'b1);
        // Automatic repeat: four back-to-back sequences until auto is cleared
        for (int k = 0; k < 4; k++) begin
            res_q.push_back({5'(k), sample_no, 1'b0, ca});
            sample_no = sample_no + 4'h1;
        end
        reg_write(ADDR_SAMPLE_CTRL, 16'h0003);
        @(posedge result_write);
        reg_read(ADDR_SAMPLE_CTRL, 16'h0002);
        repeat (2) @(posedge result_write);
        reg_write(ADDR_SAMPLE_CTRL, 16'h0000);
        repeat (20) @(posedge clk);
        `TB_CHK("results left", 0, res_q.size())
        complete_run();
    end
endmodule // testbench
`default_nettype wire
